//--- dv/acpi_pm1_wake_event_control_tb.sv
// Self-checking bench for the wake, enable and control registers.
module acpi_pm1_wake_event_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import pm1_event_pkg::*;

    logic clock_in, resetn_in, resume, standby, asleep, carry_sts, fw_en;
    logic smi_route, wake, sleeping, bm_req, bm_stat, attn_sts, fw_sts;
    logic fw_rls, sci_n, smi_n;
    logic [15:0] base_addr;
    logic [7:0] io_rdata, rd;
    io_req_t io_req;
    fw_strobe_t fw_strobe;
    int n_errors, checked;
    logic [15:0] offs [3] = '{OFF_EVT_EN1, OFF_EVT_EN2, OFF_EVT_CTL1};
    logic [7:0] live [3] = '{8'h21, 8'h00, 8'h07};

    ////////////////////////////////////////////////////////////////////////
    pm1_wake_event_control u_dut (.clock_in(clock_in), .resetn_in(resetn_in),
        .base_addr_in(base_addr), .io_req_in(io_req), .io_rdata_out(io_rdata),
        .resume_event_in(resume), .standby_expired_in(standby),
        .devices_asleep_in(asleep), .timer_carry_status_in(carry_sts),
        .firmware_event_enable_in(fw_en),
        .system_mgmt_route_enable_in(smi_route), .fw_strobe_in(fw_strobe),
        .wake_status_flag_out(wake), .chip_sleep_out(sleeping),
        .busmaster_request_flag_out(bm_req), .busmaster_status_out(bm_stat),
        .global_attention_status_out(attn_sts),
        .firmware_event_status_out(fw_sts),
        .firmware_release_bit_out(fw_rls), .sci_n_out(sci_n),
        .smi_n_out(smi_n));

    pm1_host_model u_host (.clock_in(clock_in), .base_addr_in(base_addr),
        .io_rdata_in(io_rdata), .io_req_out(io_req));

    ////////////////////////////////////////////////////////////////////////
    // Free-running 40 MHz clock.
    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(negedge clock_in);
    endtask : step

    // Strobe order, msb first: status clear, bm request, bm clear, gbl set,
    // gbl clear.
    task automatic pulse(input logic [4:0] s);
        @(negedge clock_in);
        fw_strobe = fw_strobe_t'(s);
        @(negedge clock_in);
        fw_strobe = '0;
    endtask : pulse

    // The synchroniser adds a few cycles, so the wait is bounded, not fixed.
    task automatic resume_rise();
        int n;
        n = 0;
        @(negedge clock_in);
        resume = 1'b1;
        while (wake !== 1'b1 && n < 10) begin
            @(negedge clock_in);
            n++;
        end
        resume = 1'b0;
    endtask : resume_rise

    task automatic print_verdict();
        if (n_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////
    // Watchdog sized at many times the expected run length.
    initial begin
        #(25ns * 4000);
        n_errors++;
        print_verdict();
    end

    // Main sequence of register and event scenarios.
    initial begin
        {resetn_in, resume, standby, asleep, carry_sts, fw_en, smi_route} = '0;
        base_addr = 16'h0E00;
        fw_strobe = '0;
        n_errors = 0;
        checked = 0;
        repeat (8) @(posedge clock_in);
        @(negedge clock_in);
        resetn_in = 1'b1;
        for (int i = 1; i <= 5; i++) begin
            u_host.io_read(i[15:0], rd);
            check(rd, REG_RESET);
        end
        check({sci_n, smi_n, sleeping}, 8'h06);
        for (int i = 0; i < 3; i++) begin
            u_host.io_write(offs[i], 8'hFF);
            u_host.io_read(offs[i], rd);
            check(rd, live[i]);
        end
        u_host.io_write(OFF_EVT_CTL1, 8'h00);
        u_host.io_read(OFF_EVT_CTL1, rd);
        check(rd, 8'h04);
        pulse(5'h10);
        check({fw_rls, fw_sts}, 8'h00);
        fw_en = 1'b1;
        u_host.io_write(OFF_EVT_CTL1, 8'h04);
        check({fw_rls, fw_sts}, 8'h03);
        step(2);
        check(smi_n, 8'h00);
        pulse(5'h10);
        step(2);
        check(smi_n, 8'h01);
        u_host.io_write(OFF_EVT_CTL1, 8'h01);
        u_host.io_write(OFF_EVT_EN1, 8'h01);
        carry_sts = 1'b1;
        step(2);
        check({sci_n, smi_n}, 8'h01);
        u_host.io_write(OFF_EVT_EN1, 8'h00);
        step(2);
        check(sci_n, 8'h01);
        smi_route = 1'b1;
        u_host.io_write(OFF_EVT_CTL1, 8'h00);
        u_host.io_write(OFF_EVT_EN1, 8'h01);
        step(2);
        check({sci_n, smi_n}, 8'h02);
        carry_sts = 1'b0;
        step(2);
        check(smi_n, 8'h01);
        pulse(5'h02);
        check(attn_sts, 8'h01);
        u_host.io_write(OFF_EVT_CTL1, 8'h01);
        u_host.io_write(OFF_EVT_EN1, 8'h20);
        step(2);
        check(sci_n, 8'h00);
        pulse(5'h01);
        step(2);
        check({attn_sts, sci_n}, 8'h01);
        pulse(5'h08);
        check({bm_req, bm_stat}, 8'h03);
        u_host.io_write(OFF_EVT_CTL1, 8'h03);
        step(2);
        check(sci_n, 8'h00);
        pulse(5'h04);
        step(2);
        check({bm_req, bm_stat, sci_n}, 8'h01);
        // Wake flag against sleep entry, software clear and standby expiry.
        asleep = 1'b1;
        step(3);
        check(sleeping, 8'h01);
        resume_rise();
        check(wake, 8'h01);
        step(2);
        check(sleeping, 8'h00);
        u_host.io_read(OFF_WAKE_STS, rd);
        check(rd, 8'h80);
        u_host.io_write(OFF_WAKE_STS, 8'h00);
        check(wake, 8'h01);
        u_host.io_write(OFF_WAKE_STS, 8'h80);
        check(wake, 8'h00);
        step(3);
        check(sleeping, 8'h01);
        step(4);
        resume_rise();
        check(wake, 8'h01);
        @(negedge clock_in);
        standby = 1'b1;
        @(negedge clock_in);
        standby = 1'b0;
        check(wake, 8'h00);
        print_verdict();
    end
endmodule : acpi_pm1_wake_event_control_tb

//--- dv/pm1_host_model.sv
// Host-side model that issues single-byte I/O cycles to the event block.
module pm1_host_model (
    input wire logic clock_in,
    input wire logic [15:0] base_addr_in,
    input wire logic [7:0] io_rdata_in,
    output pm1_event_pkg::io_req_t io_req_out
);
    timeunit 1ns;
    timeprecision 100ps;
    import pm1_event_pkg::*;

    // The bus starts idle with no strobe raised.
    initial begin
        io_req_out = '0;
    end

    // A released bus shows inverted address and data, never stale values.
    task automatic io_write(input logic [15:0] off, input logic [7:0] data);
        @(negedge clock_in);
        io_req_out = '{base_addr_in + off, 1'b1, 1'b0, data};
        @(negedge clock_in);
        io_req_out = '{~io_req_out.addr, 1'b0, 1'b0, ~data};
    endtask : io_write

    // Read data is registered, so it is taken one cycle after the strobe.
    task automatic io_read(input logic [15:0] off, output logic [7:0] data);
        @(negedge clock_in);
        io_req_out = '{base_addr_in + off, 1'b0, 1'b1, io_req_out.wdata};
        @(negedge clock_in);
        io_req_out = '{~io_req_out.addr, 1'b0, 1'b0, ~io_req_out.wdata};
        data = io_rdata_in;
    endtask : io_read
endmodule : pm1_host_model

//--- rtl/pin_sync3.sv
// Three-stage synchroniser that accepts a change once stages two and three agree.
module pin_sync3 (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic pin_in,
    output logic level_out
);
    logic s1_q, s2_q, s3_q, level_q;
    logic level_d;

    // The first stage feeds only the second, so metastability stays contained.
    always_comb begin
        level_d = level_q;
        if (s2_q == s3_q) begin
            level_d = s3_q;
        end
    end

    // Shift the pin through three flops and hold the accepted level.
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= level_d;
        end
    end

    assign level_out = level_q;
endmodule : pin_sync3

//--- rtl/pm1_event_pkg.sv
// Shared constants, carriers and state codes for the power event block.
package pm1_event_pkg;

    // Byte offsets of the registers relative to the programmable base.
    localparam logic [15:0] OFF_WAKE_STS = 16'h0001;
    localparam logic [15:0] OFF_EVT_EN1 = 16'h0002;
    localparam logic [15:0] OFF_EVT_EN2 = 16'h0003;
    localparam logic [15:0] OFF_EVT_CTL1 = 16'h0004;

    // Field positions inside the byte registers.
    localparam int WAKE_BIT = 7;
    localparam int CARRY_EN_BIT = 0;
    localparam int ATTN_EN_BIT = 5;
    localparam int ROUTE_BIT = 0;
    localparam int RELOAD_EN_BIT = 1;
    localparam int FW_RLS_BIT = 2;

    // Reset value of every register and the value of unmapped reads.
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // Bits of the first enable register that may read as one.
    localparam logic [7:0] EN1_LIVE_MASK = 8'h21;
    // Bits of the first control register that may read as one.
    localparam logic [7:0] CTL1_LIVE_MASK = 8'h07;

    // One host I/O cycle as seen on the system I/O port.
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } io_req_t;

    // One-cycle strobes from firmware-side logic for the first status byte.
    typedef struct packed {
        logic fw_status_clear;
        logic bm_request_write;
        logic bm_status_clear;
        logic gbl_attention_set;
        logic gbl_status_clear;
    } fw_strobe_t;

    // Sleeping/working state of the chip.
    typedef enum logic [0:0] {
        PWR_WORKING = 1'b0,
        PWR_SLEEPING = 1'b1
    } power_state_t;

endpackage : pm1_event_pkg

//--- rtl/pm1_wake_event_control.sv
// Wake status, event enable and event control registers with interrupt routing.

module pm1_wake_event_control (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [15:0] base_addr_in,
    input pm1_event_pkg::io_req_t io_req_in,
    output logic [7:0] io_rdata_out,
    input wire logic resume_event_in,
    input wire logic standby_expired_in,
    input wire logic devices_asleep_in,
    input wire logic timer_carry_status_in,
    input wire logic firmware_event_enable_in,
    input wire logic system_mgmt_route_enable_in,
    input pm1_event_pkg::fw_strobe_t fw_strobe_in,
    output logic wake_status_flag_out,
    output logic chip_sleep_out,
    output logic busmaster_request_flag_out,
    output logic busmaster_status_out,
    output logic global_attention_status_out,
    output logic firmware_event_status_out,
    output logic firmware_release_bit_out,
    output logic sci_n_out,
    output logic smi_n_out
);
    import pm1_event_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Resume pin synchronisation and edge detection.
    logic resume_lvl, resume_prev_q, resume_rise;

    pin_sync3 resume_sync (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .pin_in(resume_event_in),
        .level_out(resume_lvl)
    );

    assign resume_rise = resume_lvl && !resume_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // Address decode of the host I/O cycle.
    logic hit_wake, hit_en1, hit_en2, hit_ctl1;
    logic wr_wake, wr_en1, wr_ctl1;

    // Offsets are added to the base in 16 bits; wrap past the top is benign.
    assign hit_wake = io_req_in.addr == 16'(base_addr_in + OFF_WAKE_STS);
    assign hit_en1 = io_req_in.addr == 16'(base_addr_in + OFF_EVT_EN1);
    assign hit_en2 = io_req_in.addr == 16'(base_addr_in + OFF_EVT_EN2);
    assign hit_ctl1 = io_req_in.addr == 16'(base_addr_in + OFF_EVT_CTL1);
    assign wr_wake = io_req_in.wr && hit_wake;
    assign wr_en1 = io_req_in.wr && hit_en1;
    assign wr_ctl1 = io_req_in.wr && hit_ctl1;

    ////////////////////////////////////////////////////////////////////////
    // Register state and next values.
    power_state_t state_q, state_d;
    logic wake_q, wake_d, carry_en_q, carry_en_d, attn_en_q, attn_en_d;
    logic route_q, route_d, reload_en_q, reload_en_d, fw_rls_q, fw_rls_d;
    logic fw_sts_q, fw_sts_d, bm_req_q, bm_req_d, bm_stat_q, bm_stat_d;
    logic attn_sts_q, attn_sts_d, sci_n_q, sci_n_d, smi_n_q, smi_n_d;
    logic [7:0] rdata_q, rdata_d;
    logic set_wake, clear_wake, fw_release_write, pm_event, fw_event;

    assign set_wake = (state_q == PWR_SLEEPING) && resume_rise;
    // Only a written one or standby expiry clears; writing zero is ignored.
    assign clear_wake = (wr_wake && io_req_in.wdata[WAKE_BIT])
                        || standby_expired_in;
    assign fw_release_write = wr_ctl1 && io_req_in.wdata[FW_RLS_BIT];
    // Any enabled power event; the route decides which line carries it.
    assign pm_event = (timer_carry_status_in && carry_en_q)
                      || (attn_sts_q && attn_en_q)
                      || (reload_en_q && bm_req_q);
    assign fw_event = fw_rls_q && firmware_event_enable_in;

    // Next-value logic; for every sticky flag a set wins over a clear.
    always_comb begin
        state_d = state_q;
        wake_d = wake_q;
        if (set_wake) begin
            wake_d = 1'b1;
        end else if (clear_wake) begin
            wake_d = 1'b0;
        end
        unique case (state_q)
            PWR_SLEEPING: begin
                if (wake_q) begin
                    state_d = PWR_WORKING;
                end
            end
            PWR_WORKING: begin
                if (!wake_q && devices_asleep_in) begin
                    state_d = PWR_SLEEPING;
                end
            end
        endcase
        carry_en_d = wr_en1 ? io_req_in.wdata[CARRY_EN_BIT] : carry_en_q;
        attn_en_d = wr_en1 ? io_req_in.wdata[ATTN_EN_BIT] : attn_en_q;
        route_d = wr_ctl1 ? io_req_in.wdata[ROUTE_BIT] : route_q;
        reload_en_d = wr_ctl1 ? io_req_in.wdata[RELOAD_EN_BIT] : reload_en_q;
        // A written zero leaves the release bit alone; status clear drops it.
        fw_rls_d = fw_rls_q;
        fw_sts_d = fw_sts_q;
        if (fw_release_write) begin
            fw_rls_d = 1'b1;
            fw_sts_d = 1'b1;
        end else if (fw_strobe_in.fw_status_clear) begin
            fw_rls_d = 1'b0;
            fw_sts_d = 1'b0;
        end
        bm_req_d = bm_req_q;
        bm_stat_d = bm_stat_q;
        if (fw_strobe_in.bm_request_write) begin
            bm_req_d = 1'b1;
            bm_stat_d = 1'b1;
        end else if (fw_strobe_in.bm_status_clear) begin
            bm_req_d = 1'b0;
            bm_stat_d = 1'b0;
        end
        attn_sts_d = attn_sts_q;
        if (fw_strobe_in.gbl_attention_set) begin
            attn_sts_d = 1'b1;
        end else if (fw_strobe_in.gbl_status_clear) begin
            attn_sts_d = 1'b0;
        end
        // Lines follow their causes, so they hold until all causes clear.
        sci_n_d = !(route_q && pm_event);
        smi_n_d = !((!route_q && system_mgmt_route_enable_in && pm_event)
                    || fw_event);
        // Read data is captured on a read and held until the next one.
        rdata_d = rdata_q;
        if (io_req_in.rd) begin
            rdata_d = READ_ZERO;
            if (hit_wake) begin
                rdata_d[WAKE_BIT] = wake_q;
            end else if (hit_en1) begin
                rdata_d[CARRY_EN_BIT] = carry_en_q;
                rdata_d[ATTN_EN_BIT] = attn_en_q;
            end else if (hit_ctl1) begin
                rdata_d[ROUTE_BIT] = route_q;
                rdata_d[RELOAD_EN_BIT] = reload_en_q;
                rdata_d[FW_RLS_BIT] = fw_rls_q;
            end
        end
    end

    // Register every piece of state; interrupt lines idle high.
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= PWR_WORKING;
            resume_prev_q <= 1'b0;
            wake_q <= 1'b0;
            carry_en_q <= 1'b0;
            attn_en_q <= 1'b0;
            route_q <= 1'b0;
            reload_en_q <= 1'b0;
            fw_rls_q <= 1'b0;
            fw_sts_q <= 1'b0;
            bm_req_q <= 1'b0;
            bm_stat_q <= 1'b0;
            attn_sts_q <= 1'b0;
            sci_n_q <= 1'b1;
            smi_n_q <= 1'b1;
            rdata_q <= REG_RESET;
        end else begin
            state_q <= state_d;
            resume_prev_q <= resume_lvl;
            wake_q <= wake_d;
            carry_en_q <= carry_en_d;
            attn_en_q <= attn_en_d;
            route_q <= route_d;
            reload_en_q <= reload_en_d;
            fw_rls_q <= fw_rls_d;
            fw_sts_q <= fw_sts_d;
            bm_req_q <= bm_req_d;
            bm_stat_q <= bm_stat_d;
            attn_sts_q <= attn_sts_d;
            sci_n_q <= sci_n_d;
            smi_n_q <= smi_n_d;
            rdata_q <= rdata_d;
        end
    end

    assign io_rdata_out = rdata_q;
    assign wake_status_flag_out = wake_q;
    assign chip_sleep_out = state_q == PWR_SLEEPING;
    assign busmaster_request_flag_out = bm_req_q;
    assign busmaster_status_out = bm_stat_q;
    assign global_attention_status_out = attn_sts_q;
    assign firmware_event_status_out = fw_sts_q;
    assign firmware_release_bit_out = fw_rls_q;
    assign sci_n_out = sci_n_q;
    assign smi_n_out = smi_n_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the block's own behaviour.
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);

    wake_set_a: assert property (set_wake |=> wake_q)
        else $error("wake flag not set by resume while sleeping");
    wake_work_a: assert property (chip_sleep_out && wake_q
        |=> !chip_sleep_out)
        else $error("wake flag did not return chip to working");
    wake_clear_a: assert property (wake_q && standby_expired_in
        && !set_wake |=> !wake_q)
        else $error("standby expiry did not clear wake flag");
    wake_hold_a: assert property (wake_q && !standby_expired_in
        && !(wr_wake && io_req_in.wdata[WAKE_BIT]) |=> wake_q)
        else $error("wake flag cleared without cause");
    chip_sleep_a: assert property (!chip_sleep_out && !wake_q
        && devices_asleep_in |=> chip_sleep_out)
        else $error("chip did not enter sleeping state");
    tmr_irq_a: assert property (route_q && carry_en_q
        && timer_carry_status_in |=> !sci_n_out)
        else $error("timer carry did not raise control interrupt");
    gbl_irq_a: assert property (route_q && attn_en_q && attn_sts_q
        |=> !sci_n_out)
        else $error("global attention did not raise control interrupt");
    rsvd_en1_a: assert property (io_req_in.rd && hit_en1
        |=> (io_rdata_out & ~EN1_LIVE_MASK) == READ_ZERO)
        else $error("reserved enable bits read as one");
    rsvd_ctl_a: assert property (io_req_in.rd && (hit_en2 || hit_ctl1)
        |=> (io_rdata_out & ~CTL1_LIVE_MASK) == READ_ZERO)
        else $error("reserved control or enable bits read as one");
    sci_route_a: assert property (!route_q |=> sci_n_out)
        else $error("control interrupt with route select clear");
    smi_route_a: assert property (!route_q && pm_event
        && system_mgmt_route_enable_in |=> !smi_n_out)
        else $error("power event not routed to management interrupt");
    bm_irq_a: assert property (route_q && reload_en_q && bm_req_q
        |=> !sci_n_out)
        else $error("bus-master reload did not raise interrupt");
    fw_set_a: assert property (fw_release_write
        |=> ((fw_rls_q && fw_sts_q) and (firmware_event_enable_in
        |=> !smi_n_out)))
        else $error("firmware release did not set status or interrupt");
    fw_clear_a: assert property (fw_strobe_in.fw_status_clear
        && !fw_release_write |=> !fw_sts_q && !fw_rls_q)
        else $error("firmware status clear left release set");
    bm_set_a: assert property (fw_strobe_in.bm_request_write
        |=> bm_req_q && bm_stat_q)
        else $error("bus-master request did not set both flags");
    attn_hold_a: assert property (!fw_strobe_in.gbl_attention_set
        && !fw_strobe_in.gbl_status_clear |=> $stable(attn_sts_q))
        else $error("global attention status changed without cause");
    irq_hold_a: assert property (!pm_event && !fw_event
        |=> sci_n_out && smi_n_out)
        else $error("interrupt stayed asserted with no cause");

    wake_cycle_c: cover property (set_wake ##1 wake_q ##1 !chip_sleep_out);
    sci_raise_c: cover property (sci_n_out ##1 !sci_n_out ##[1:20] sci_n_out);
    fw_smi_c: cover property (fw_release_write ##[1:4] !smi_n_out);
endmodule : pm1_wake_event_control
